// File: rtl/nfbc_pkg.sv
// nfbc_pkg: constants, commands and carrier types for the flash host
// assumes one 250 MHz core clock; no timing table beyond a few counts
package nfbc_pkg;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 31;
    localparam int FIFO_DEPTH = 32;
    localparam int CLK_PERIOD_PS = 4000;
    // strobe phase times, figures as chosen for this host
    localparam int STROBE_LOW_PS = 12000;
    localparam int STROBE_HIGH_PS = 12000;
    localparam int READ_ACCESS_DELAY_PS = 20000;
    localparam int STROBE_LOW_CYC =
        (STROBE_LOW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STROBE_HIGH_CYC =
        (STROBE_HIGH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int READ_ACCESS_CYC =
        (READ_ACCESS_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PAGE_BYTES = 2112;
    localparam int SPARE_FIRST_COL = 2048;
    localparam int PAGE_COUNT = 524288;
    localparam int BLOCK_COUNT = 8192;
    localparam logic [7:0] CMD_READ_SETUP = 8'h00;
    localparam logic [7:0] CMD_READ_GO = 8'h30;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
    localparam logic [7:0] CMD_PROG_GO = 8'h10;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
    localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
    localparam logic [7:0] CMD_RESET = 8'hFF;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [2:0] ROW_CYCLES = 3'h3;
    localparam logic [2:0] ALL_ADDR_CYCLES = 3'h5;

    typedef enum logic [2:0] {
        NFBC_OP_READ = 3'h0,
        NFBC_OP_PROG = 3'h1,
        NFBC_OP_ERASE = 3'h2,
        NFBC_OP_RESET = 3'h3,
        NFBC_OP_STATUS = 3'h4
    } nfbc_op_t;

    typedef struct packed {
        nfbc_op_t op;
        logic die;
        logic [ADDR_W-1:0] addr;
        logic [11:0] count;
    } nfbc_req_t;

    typedef struct packed {
        logic cmdLatch;
        logic addrLatch;
        logic writeStrobeN;
        logic readStrobeN;
        logic writeProtectN;
    } nfbc_ctl_t;
endpackage

// File: rtl/nfbc_fifo.sv
// nfbc_fifo: synchronous fifo for write data toward the flash
// assumes one clock; read data come out of a register
`timescale 1ns/1ps
module nfbc_fifo import nfbc_pkg::*; #(
    parameter int WIDTH = 8,
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
        logic valid;
        logic [WIDTH-1:0] data;
        logic ready;
    } nfbc_fifo_st_t;
    nfbc_fifo_st_t st, next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic full, empty, doWrite, doRead;

    // output register counts toward depth, so only DEPTH words fit
    assign full = !st.ready;
    assign empty = st.wp == st.rp;
    assign inReady = st.ready;
    assign doWrite = inValid && !full;
    // output register refills whenever it is empty or being taken
    assign doRead = !empty && (!st.valid || outReady);
    assign outValid = st.valid;
    assign outData = st.data;

    always_comb begin
        next_st = st;
        if (doWrite) begin
            next_st.wp = st.wp + 1'b1;
        end
        if (doRead) begin
            next_st.rp = st.rp + 1'b1;
            next_st.valid = 1'b1;
            next_st.data = mem[st.rp[AW-1:0]];
        end else if (outReady) begin
            next_st.valid = 1'b0;
        end
        next_st.ready = (next_st.wp - next_st.rp +
            {{AW{1'b0}}, next_st.valid}) != (AW+1)'(DEPTH);
    end

    always_ff @(posedge core_clk) begin
        if (doWrite) begin
            mem[st.wp[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.ready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end
endmodule

// File: rtl/nfbc_host.sv
// nfbc_host: host sequencer driving a two-die nand flash bus
// assumes the flash pins are asynchronous to core_clk; ready/busy pulled up
`timescale 1ns/1ps
// Summary of operation
// - command latch high, byte taken at rise
// - address latch high, byte taken at rise
// - host pulses write strobe, select held low
// - five address cycles, column then row
// - address bits packed, unused lines low
// - reset/status one cycle, others two
// - read and program send five addresses
// - erase sends three row cycles only
// - fixed command codes per operation
module nfbc_host import nfbc_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // request side
    input wire logic reqValid,
    output logic reqReady,
    input nfbc_req_t req,
    input wire logic writeProtectReq,
    // program data in
    input wire logic wrValid,
    output logic wrReady,
    input wire logic [BYTE_W-1:0] wrData,
    // read data out
    output logic rdValid,
    output logic [BYTE_W-1:0] rdData,
    output logic done,
    // flash pins
    output nfbc_ctl_t flashCtl,
    output logic first_die_select_n,
    output logic second_die_select_n,
    input wire logic [BYTE_W-1:0] byte_port_in,
    output logic [BYTE_W-1:0] byte_port_out,
    output logic byte_port_oe,
    input wire logic first_die_ready_busy_n,
    input wire logic second_die_ready_busy_n
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_CMD1 = 4'h1,
        ST_ADDR = 4'h2,
        ST_DATA = 4'h3,
        ST_CMD2 = 4'h4,
        ST_WAITB = 4'h5,
        ST_READ = 4'h6,
        ST_STAT = 4'h7,
        ST_WAITR = 4'h8
    } nfbc_state_t;
    typedef struct packed {
        nfbc_state_t state;
        nfbc_op_t op;
        logic die;
        logic [ADDR_W-1:0] addr;
        logic [11:0] left;
        logic [2:0] addrIdx;
        logic [1:0] phase;
        logic [3:0] cnt;
        logic [1:0] rbSync1, rbSync2;
        logic [BYTE_W-1:0] pinSync1, pinSync2;
        logic rdValid;
        logic [BYTE_W-1:0] rdData;
        logic done;
        nfbc_ctl_t ctl;
        logic selN0, selN1;
        logic [BYTE_W-1:0] portOut;
        logic portOe;
        logic reqReady;
    } nfbc_host_st_t;
    nfbc_host_st_t st, next_st;
    logic fifoValid, fifoTake;
    logic [BYTE_W-1:0] fifoData;
    nfbc_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) wrFifo (
        .core_clk(core_clk),
        .rst(rst),
        .inValid(wrValid),
        .inReady(wrReady),
        .inData(wrData),
        .outValid(fifoValid),
        .outReady(fifoTake),
        .outData(fifoData)
    );
    // address byte per cycle, unused lines driven low
    function automatic logic [7:0] addrByte(input logic [ADDR_W-1:0] a,
                                            input logic [2:0] i);
        unique case (i)
            3'h0: addrByte = a[7:0];
            3'h1: addrByte = {4'h0, a[11:8]};
            3'h2: addrByte = a[19:12];
            3'h3: addrByte = a[27:20];
            default: addrByte = {5'h00, a[30:28]};
        endcase
    endfunction
    function automatic logic [7:0] setupCode(input nfbc_op_t op);
        unique case (op)
            NFBC_OP_READ: setupCode = CMD_READ_SETUP;
            NFBC_OP_PROG: setupCode = CMD_PROG_SETUP;
            NFBC_OP_ERASE: setupCode = CMD_ERASE_SETUP;
            NFBC_OP_RESET: setupCode = CMD_RESET;
            default: setupCode = CMD_STATUS;
        endcase
    endfunction
    logic dieReady, cycleEnd;
    // each die watched on its own ready/busy line
    assign dieReady = st.die ? st.rbSync2[1] : st.rbSync2[0];
    // strobe finished: low phase then high phase both counted out
    assign cycleEnd = (st.phase == 2'h2) &&
        (st.cnt == 4'(STROBE_HIGH_CYC - 1));
    assign fifoTake = (st.state == ST_DATA) && cycleEnd && fifoValid;
    always_comb begin
        next_st = st;
        next_st.rbSync1 = {second_die_ready_busy_n, first_die_ready_busy_n};
        next_st.rbSync2 = st.rbSync1;
        next_st.pinSync1 = byte_port_in;
        next_st.pinSync2 = st.pinSync1;
        next_st.rdValid = 1'b0;
        next_st.done = 1'b0;
        next_st.ctl.writeProtectN = !writeProtectReq;
        // strobe phase engine: 1 = strobe low, 2 = strobe high
        if (st.phase == 2'h1) begin
            next_st.cnt = st.cnt + 4'h1;
            if (st.cnt == 4'(STROBE_LOW_CYC - 1)) begin
                next_st.phase = 2'h2;
                next_st.cnt = 4'h0;
                // write strobe rises with latch held
                next_st.ctl.writeStrobeN = 1'b1;
                next_st.ctl.readStrobeN = 1'b1;
            end
        end else if (st.phase == 2'h2) begin
            next_st.cnt = st.cnt + 4'h1;
            if (cycleEnd) begin
                next_st.phase = 2'h0;
                next_st.cnt = 4'h0;
            end
        end
        unique case (st.state)
            ST_IDLE: begin
                if (reqValid) begin
                    next_st.op = req.op;
                    next_st.die = req.die;
                    next_st.addr = req.addr;
                    next_st.left = req.count;
                    next_st.state = ST_WAITR;
                end
            end
            ST_WAITR: begin
                // only reset and status skip the wait
                if (dieReady || st.op == NFBC_OP_RESET ||
                    st.op == NFBC_OP_STATUS) begin
                    next_st.state = ST_CMD1;
                    next_st.selN0 = st.die;
                    next_st.selN1 = !st.die;
                end
            end
            ST_CMD1: begin
                if (st.phase == 2'h0 && !cycleEnd) begin
                    next_st.ctl.cmdLatch = 1'b1;
                    next_st.ctl.writeStrobeN = 1'b0;
                    next_st.portOut = setupCode(st.op);
                    next_st.portOe = 1'b1;
                    next_st.phase = 2'h1;
                end
                if (cycleEnd) begin
                    next_st.ctl.cmdLatch = 1'b0;
                    // reset and status are single cycle
                    next_st.addrIdx = (st.op == NFBC_OP_ERASE) ? 3'h2 : 3'h0;
                    unique case (st.op)
                        NFBC_OP_RESET: next_st.state = ST_WAITB;
                        NFBC_OP_STATUS: next_st.state = ST_STAT;
                        default: next_st.state = ST_ADDR;
                    endcase
                end
            end
            ST_ADDR: begin
                if (st.phase == 2'h0 && !cycleEnd) begin
                    next_st.ctl.addrLatch = 1'b1;
                    next_st.ctl.writeStrobeN = 1'b0;
                    next_st.portOut = addrByte(st.addr, st.addrIdx);
                    next_st.phase = 2'h1;
                end
                if (cycleEnd) begin
                    next_st.addrIdx = st.addrIdx + 3'h1;
                    // all five cycles for read and program
                    if (st.addrIdx == 3'(ALL_ADDR_CYCLES - 1)) begin
                        next_st.ctl.addrLatch = 1'b0;
                        next_st.state = (st.op == NFBC_OP_PROG) ?
                            ST_DATA : ST_CMD2;
                    end
                end
            end
            ST_DATA: begin
                if (st.left == 12'h000) begin
                    next_st.state = ST_CMD2;
                end else if (st.phase == 2'h0 && !cycleEnd && fifoValid) begin
                    next_st.ctl.writeStrobeN = 1'b0;
                    next_st.portOut = fifoData;
                    next_st.phase = 2'h1;
                end
                if (fifoTake) begin
                    next_st.left = st.left - 12'h001;
                end
            end
            ST_CMD2: begin
                if (st.phase == 2'h0 && !cycleEnd) begin
                    next_st.ctl.cmdLatch = 1'b1;
                    next_st.ctl.writeStrobeN = 1'b0;
                    next_st.portOut = (st.op == NFBC_OP_READ) ? CMD_READ_GO :
                        (st.op == NFBC_OP_PROG) ? CMD_PROG_GO : CMD_ERASE_GO;
                    next_st.phase = 2'h1;
                end
                if (cycleEnd) begin
                    next_st.ctl.cmdLatch = 1'b0;
                    next_st.state = ST_WAITB;
                end
            end
            ST_WAITB: begin
                // wait for busy to clear, after sync delay
                next_st.portOe = 1'b0;
                if (st.cnt != 4'hF) begin
                    next_st.cnt = st.cnt + 4'h1;
                end else if (dieReady) begin
                    next_st.cnt = 4'h0;
                    if (st.op == NFBC_OP_READ && st.left != 12'h000) begin
                        next_st.state = ST_READ;
                    end else begin
                        next_st.done = 1'b1;
                        next_st.selN0 = 1'b1;
                        next_st.selN1 = 1'b1;
                        next_st.state = ST_IDLE;
                    end
                end
            end
            ST_STAT, ST_READ: begin
                next_st.portOe = 1'b0;
                if (st.phase == 2'h0 && !cycleEnd) begin
                    // each read strobe fall gives next byte
                    next_st.ctl.readStrobeN = 1'b0;
                    next_st.phase = 2'h1;
                end
                if (st.phase == 2'h2 && st.cnt == 4'h0) begin
                    next_st.rdValid = 1'b1;
                    next_st.rdData = st.pinSync2;
                    next_st.left = st.left - 12'h001;
                end
                if (cycleEnd && (st.state == ST_STAT ||
                                 st.left == 12'h000)) begin
                    next_st.done = 1'b1;
                    next_st.selN0 = 1'b1;
                    next_st.selN1 = 1'b1;
                    next_st.state = ST_IDLE;
                end
            end
        endcase
        next_st.reqReady = next_st.state == ST_IDLE;
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.ctl.writeStrobeN <= 1'b1;
            st.ctl.readStrobeN <= 1'b1;
            st.selN0 <= 1'b1;
            st.selN1 <= 1'b1;
            st.reqReady <= 1'b1;
        end else begin
            st <= next_st;
        end
    end
    assign flashCtl = st.ctl;
    assign reqReady = st.reqReady;
    assign first_die_select_n = st.selN0;
    assign second_die_select_n = st.selN1;
    assign byte_port_out = st.portOut;
    assign byte_port_oe = st.portOe;
    assign rdValid = st.rdValid;
    assign rdData = st.rdData;
    assign done = st.done;
    AST_WR_UNDER_SELECT: assert property (@(posedge core_clk) disable iff (rst)
        !st.ctl.writeStrobeN |-> (!st.selN0 || !st.selN1))
        else $error("write strobe low with no die selected");
    AST_CMD_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        $rose(st.ctl.writeStrobeN) && st.state == ST_CMD1 |->
        st.ctl.cmdLatch && !st.ctl.addrLatch)
        else $error("command latch dropped before strobe rise");
    AST_ADDR_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        $rose(st.ctl.writeStrobeN) && st.state == ST_ADDR |->
        st.ctl.addrLatch && !st.ctl.cmdLatch)
        else $error("address latch dropped before strobe rise");
    AST_UNUSED_LOW: assert property (@(posedge core_clk) disable iff (rst)
        st.state == ST_ADDR && st.phase != 2'h0 && st.addrIdx == 3'h1 |->
        st.portOut[7:4] == 4'h0)
        else $error("unused column lines not low");
    AST_ERASE_ROWS: assert property (@(posedge core_clk) disable iff (rst)
        st.state == ST_ADDR && st.op == NFBC_OP_ERASE |->
        st.addrIdx >= 3'h2)
        else $error("erase sent a column cycle");
    AST_ONE_DIE: assert property (@(posedge core_clk) disable iff (rst)
        !(st.selN0 == 1'b0 && st.selN1 == 1'b0))
        else $error("both dies selected");
    AST_WAIT_READY: assert property (@(posedge core_clk) disable iff (rst)
        st.state == ST_WAITR ##1 st.state == ST_CMD1 &&
        st.op inside {NFBC_OP_READ, NFBC_OP_PROG, NFBC_OP_ERASE} |->
        $past(dieReady))
        else $error("command issued to busy die");
    AST_READ_CODE: assert property (@(posedge core_clk) disable iff (rst)
        st.state == ST_CMD2 && st.ctl.cmdLatch && st.op == NFBC_OP_READ |->
        st.portOut == CMD_READ_GO)
        else $error("wrong read execute code");
    AST_FLOAT_READ: assert property (@(posedge core_clk) disable iff (rst)
        !st.ctl.readStrobeN |-> !st.portOe)
        else $error("host drives port during read");
    AST_DONE_IDLE: assert property (@(posedge core_clk) disable iff (rst)
        st.done |-> st.state == ST_IDLE && st.selN0 && st.selN1)
        else $error("done without release");
    COV_PROG: cover property (@(posedge core_clk)
        st.state == ST_DATA ##[1:1000] st.state == ST_CMD2);
    COV_READ: cover property (@(posedge core_clk) st.rdValid);
    COV_ERASE: cover property (@(posedge core_clk)
        st.op == NFBC_OP_ERASE && st.done);
endmodule

// File: tb/nfbc_die_model.sv
// nfbc_die_model: behavioural flash die answering the host's bus pins
// assumes the bench resolves the shared byte bus and the ready pull-up
`timescale 1ns/1ps
module nfbc_die_model import nfbc_pkg::*; #(
    parameter int BUSY_NS = 400,
    parameter int ACCESS_NS = 6,
    parameter int HOLD_NS = 6
) (
    // pins of this die
    input wire nfbc_ctl_t flashCtl,
    input wire logic selectN,
    input wire logic [7:0] busIn,
    output logic [7:0] dataOut,
    output logic dataOe,
    output logic pullLow,
    // address bytes taken, newest on top
    output logic [39:0] addrLog,
    output logic [2:0] addrCnt
);
    logic [7:0] pageReg [0:PAGE_BYTES-1];
    logic [7:0] mem [longint];
    logic [7:0] rdByte;
    logic [11:0] col = 12'h000;
    logic [18:0] row;
    logic busy = 1'b0;
    logic statusMode = 1'b0;
    longint base;
    event goBusy;

    initial begin
        dataOut = 8'h00;
        dataOe = 1'b0;
        addrLog = 40'h0;
        addrCnt = 3'h0;
    end
    assign row = {addrLog[34:32], addrLog[31:16]};

    assign pullLow = busy;
    always begin
        @(goBusy);
        busy = 1'b1;
        #(BUSY_NS);
        busy = 1'b0;
    end

    task automatic command(input logic [7:0] c);
        statusMode = (c == CMD_STATUS);
        if (c == CMD_RESET)
            busy = 1'b0;
        if (busy)
            return;
        base = longint'(row) * PAGE_BYTES;
        case (c)
            CMD_READ_SETUP, CMD_PROG_SETUP, CMD_ERASE_SETUP: begin
                addrCnt = 3'h0;
                addrLog = 40'h0;
                if (c == CMD_PROG_SETUP)
                    foreach (pageReg[i]) pageReg[i] = 8'hFF;
            end
            CMD_READ_GO: begin
                for (int i = 0; i < PAGE_BYTES; i++)
                    pageReg[i] = mem.exists(base + i) ? mem[base + i] : 8'hFF;
                -> goBusy;
            end
            CMD_PROG_GO: begin
                for (int i = 0; i < PAGE_BYTES; i++)
                    if (flashCtl.writeProtectN) mem[base + i] = pageReg[i];
                -> goBusy;
            end
            CMD_ERASE_GO: begin
                base = longint'({row[18:6], 6'h00}) * PAGE_BYTES;
                for (int i = 0; i < 64 * PAGE_BYTES; i++)
                    if (flashCtl.writeProtectN) mem.delete(base + i);
                -> goBusy;
            end
            default: ;
        endcase
    endtask

    always @(posedge flashCtl.writeStrobeN) if (selectN === 1'b0) begin
        if (flashCtl.cmdLatch)
            command(busIn);
        else if (flashCtl.addrLatch) begin
            if (addrCnt < 3'h5) begin
                addrLog = {busIn, addrLog[39:8]};
                addrCnt = addrCnt + 3'h1;
                col = {addrLog[11:8], addrLog[7:0]};
            end
        end else if (!busy && col < PAGE_BYTES) begin
            pageReg[col] = busIn;
            col = col + 12'h1;
        end
    end

    always @(negedge flashCtl.readStrobeN) if (selectN === 1'b0) begin
        rdByte = statusMode ? {flashCtl.writeProtectN, !busy, 6'h00}
                            : pageReg[col];
        if (!statusMode && col < PAGE_BYTES - 1)
            col = col + 12'h1;
        #(ACCESS_NS);
        dataOut = rdByte;
        dataOe = 1'b1;
    end

    always @(posedge flashCtl.readStrobeN or posedge selectN) begin
        #(HOLD_NS);
        dataOe = 1'b0;
    end
endmodule

// File: tb/test_nand_flash_bus_cycle_interface.sv
// test_nand_flash_bus_cycle_interface: host against two die models
// assumes tb/nfbc_die_model.sv; ready/busy lines pulled up here
`timescale 1ns/1ps
module test_nand_flash_bus_cycle_interface import nfbc_pkg::*; ;
    localparam logic [30:0] ADDR_A = 31'h4ABC_D820;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic reqValid = 1'b0;
    nfbc_req_t req = '0;
    logic writeProtectReq = 1'b0;
    logic wrValid = 1'b0;
    logic [7:0] wrData = 8'h00;
    logic reqReady, wrReady, rdValid, done, sel0N, sel1N, hostOe;
    logic oe0, oe1, low0, low1;
    logic [7:0] rdData, hostOut, busNow, d0, d1;
    logic [7:0] lastBus = 8'h00;
    logic [39:0] log0, log1;
    logic [2:0] cnt0, cnt1;
    nfbc_ctl_t flashCtl;
    logic [7:0] got [$];
    int failures = 0;
    int compares = 0;
    int cycles = 0;

    always #2 core_clk = ~core_clk;
    // released bus shows the inverse of its last value
    assign busNow = hostOe ? hostOut : oe0 ? d0 : oe1 ? d1 : ~lastBus;
    always @(posedge core_clk) if (hostOe | oe0 | oe1) lastBus <= busNow;

    nfbc_host nfbc_host_i (.core_clk(core_clk), .rst(rst),
        .reqValid(reqValid), .reqReady(reqReady), .req(req),
        .writeProtectReq(writeProtectReq), .wrValid(wrValid),
        .wrReady(wrReady), .wrData(wrData), .rdValid(rdValid),
        .rdData(rdData), .done(done), .flashCtl(flashCtl),
        .first_die_select_n(sel0N), .second_die_select_n(sel1N),
        .byte_port_in(busNow), .byte_port_out(hostOut),
        .byte_port_oe(hostOe), .first_die_ready_busy_n(~low0),
        .second_die_ready_busy_n(~low1));
    nfbc_die_model nfbc_die_model_i0 (.flashCtl(flashCtl), .selectN(sel0N),
        .busIn(busNow), .dataOut(d0), .dataOe(oe0), .pullLow(low0),
        .addrLog(log0), .addrCnt(cnt0));
    nfbc_die_model nfbc_die_model_i1 (.flashCtl(flashCtl), .selectN(sel1N),
        .busIn(busNow), .dataOut(d1), .dataOe(oe1), .pullLow(low1),
        .addrLog(log1), .addrCnt(cnt1));

    // strobe needs one idle selected die
    always @(negedge flashCtl.writeStrobeN) if (!rst) begin
        if (sel0N === sel1N || (!sel0N && low0) || (!sel1N && low1)) begin
            failures++;
            $display("[FAIL] %0t write strobe with bad select", $time);
        end
    end

    task automatic summarize();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            $display("[FAIL] %0t run timed out", $time);
            summarize();
        end
    end

    task automatic check(input logic [39:0] g, input logic [39:0] e,
                         input string what);
        compares++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, g, e);
        end
    endtask

    task automatic run(input nfbc_op_t op, input logic die,
                       input logic [30:0] a, input logic [11:0] n);
        int k;
        got.delete();
        @(posedge core_clk);
        reqValid <= 1'b1;
        req <= '{op: op, die: die, addr: a, count: n};
        do @(negedge core_clk); while (reqReady !== 1'b1);
        @(posedge core_clk);
        reqValid <= 1'b0;
        for (k = 0; k < 5000 && done !== 1'b1; k++) begin
            @(negedge core_clk);
            if (rdValid === 1'b1)
                got.push_back(rdData);
        end
        check(40'(k < 5000), 40'h1, "done seen");
    endtask

    task automatic testProgramRead();
        int n = 0;
        while (n < 40) begin
            @(posedge core_clk);
            wrValid <= 1'b1;
            wrData <= 8'hA0 + 8'(n);
            @(negedge core_clk);
            if (wrReady !== 1'b1)
                break;
            n++;
        end
        @(posedge core_clk);
        wrValid <= 1'b0;
        check(40'(n), 40'(FIFO_DEPTH), "fifo fill");
        run(NFBC_OP_PROG, 1'b0, ADDR_A, 12'h020);
        check(cnt0, 3'h5, "program address cycles");
        check(log0, {5'h00, ADDR_A[30:12], 4'h0, ADDR_A[11:0]},
              "address bytes");
        check(wrReady, 1'b1, "fifo drained");
        run(NFBC_OP_READ, 1'b0, ADDR_A, 12'h020);
        check(40'(got.size()), 40'h20, "read count");
        foreach (got[i]) check(got[i], 8'hA0 + 8'(i), "read byte");
        $display("test program read done");
    endtask

    task automatic testErase();
        run(NFBC_OP_ERASE, 1'b0, ADDR_A, 12'h000);
        check(cnt0, 3'h3, "erase address cycles");
        check(log0 >> 16, {21'h0, ADDR_A[30:12]}, "erase rows");
        run(NFBC_OP_READ, 1'b0, ADDR_A, 12'h002);
        check(40'(got.size()), 40'h2, "erased count");
        foreach (got[i]) check(got[i], 8'hFF, "erased byte");
        $display("test erase done");
    endtask

    task automatic testStatusProtect();
        run(NFBC_OP_STATUS, 1'b1, 31'h0, 12'h001);
        check(40'(got.size()), 40'h1, "status count");
        check(got[0], 8'hC0, "status idle");
        writeProtectReq <= 1'b1;
        @(posedge core_clk);
        wrValid <= 1'b1;
        wrData <= 8'h5A;
        do @(negedge core_clk); while (wrReady !== 1'b1);
        @(posedge core_clk);
        wrValid <= 1'b0;
        run(NFBC_OP_PROG, 1'b1, 31'h0000_1000, 12'h001);
        check(cnt0, 3'h5, "other die untouched");
        run(NFBC_OP_READ, 1'b1, 31'h0000_1000, 12'h001);
        check(got[0], 8'hFF, "protected page");
        run(NFBC_OP_STATUS, 1'b1, 31'h0, 12'h001);
        check(got[0], 8'h40, "status protected");
        writeProtectReq <= 1'b0;
        run(NFBC_OP_RESET, 1'b1, 31'h0, 12'h000);
        $display("test status protect done");
    endtask

    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        testProgramRead();
        testErase();
        testStatusProtect();
        summarize();
    end
endmodule
